// >>> rtl/esr_map.svh
// register offsets, field positions and reset values of the serial port
`ifndef ESR_MAP_SVH
`define ESR_MAP_SVH
`define ESR_OFF_TXSC    3'h0
`define ESR_OFF_RXSC    3'h1
`define ESR_OFF_BAUDC   3'h2
`define ESR_OFF_DIVL    3'h3
`define ESR_OFF_DIVH    3'h4
`define ESR_OFF_RXDATA  3'h5
`define ESR_OFF_ODC     3'h6
`define ESR_OFF_INTC    3'h7
`define ESR_RXSC_PORT_ENABLE_BIT   7
`define ESR_RXSC_RX9    6
`define ESR_RXSC_CONTINUOUS_RECEIVE_ENABLE   4
`define ESR_RXSC_ADDRESS_DETECT_ENABLE  3
`define ESR_RXSC_FERR   2
`define ESR_RXSC_OERR   1
`define ESR_RXSC_D9     0
`define ESR_TXSC_CSRC   7
`define ESR_TXSC_TXEN   5
`define ESR_TXSC_SYNC   4
`define ESR_TXSC_BRK    3
`define ESR_TXSC_HIGH_SPEED_BAUD_SELECT   2
`define ESR_BAUDC_POL   4
`define ESR_BAUDC_B16   3
`define ESR_BAUDC_WUE   1
`define ESR_BAUDC_ABD   0
`define ESR_INTC_RCF    0
`define ESR_INTC_RCIE   1
`define ESR_INTC_RCIP   2
`define ESR_OSR_LAST    4'hf
`define ESR_OSR_MID     4'h7
`define ESR_BRK_BITS    4'hc
`define ESR_ZERO8       8'h00
`endif

// >>> rtl/esr_pkg.sv
// types of the serial receiver
package esr_pkg;
	typedef enum logic [3:0] {
		ESR_IDLE  = 4'b0001,
		ESR_START = 4'b0010,
		ESR_DATA  = 4'b0100,
		ESR_STOP  = 4'b1000
	} esr_state_t;
endpackage : esr_pkg

// >>> rtl/esr_top.sv
// enhanced serial receiver with register port and pin control
// Function
// - bits recovered at sixteen samples per bit, shifted per bit time
// - modes: async, sync master, sync slave; clock polarity selectable
// - async transmitter can send a twelve-bit break
// - pins taken over only while port enable bit is set
// - transmit/clock pin direction switches automatically with the active mode; receive pin stays input
// - driven transmit/clock pin is push-pull by default
// - open-drain select drives low only, releases when high
// - baud from divisor pair, modified by high-speed and 16-bit selects
// - async operation when sync bit clear and port enabled
// - nine-bit select makes receiver take nine data bits
// - characters accepted only while continuous receive enable set
// - receive-complete flag on character; interrupt if enabled
// - status register shows ninth bit and error indications
// - receive data register returns low eight data bits
// - clearing continuous receive enable clears receive errors
// - address detect enable with nine bits selects address mode
// - no address detect: characters enter buffer and interrupt unless the flag is still set (overrun)
// - priority bit routes receive interrupt to high or low level
`timescale 1ns/1ps
`include "esr_map.svh"
module esr_top
	import esr_pkg::*;
(
	input  wire logic       clk_sys,   // system clock, 100 MHz
	input  wire logic       sys_rst,   // sync reset, active high
	input  wire logic       clk_en,    // freezes state when low
	input  wire logic [2:0] reg_addr,  // register offset
	input  wire logic [7:0] reg_wdata, // write data
	input  wire logic       reg_wr,    // write strobe
	input  wire logic       reg_rd,    // read strobe
	output logic      [7:0] reg_rdata, // read data, cycle after strobe
	input  wire logic       rx_in,     // receive pin input
	output logic            rx_out,    // receive pin output, held high and never enabled
	output logic            rx_oe,     // receive pin enable
	input  wire logic       txck_in,   // transmit/clock pin input
	output logic            txck_out,  // transmit/clock pin output
	output logic            txck_oe,   // transmit/clock pin enable
	output logic            irq_high,  // receive interrupt, high level
	output logic            irq_low    // receive interrupt, low level
);
	logic [7:0] txsc_q, rxsc_q, baudc_q, divl_q, divh_q, rxdata_q, intc_q;
	logic       od_q;
	logic [15:0] brg_cnt_q;
	logic [1:0]  pre_q;
	logic        tick_q;
	esr_state_t  st_q;
	logic [3:0]  smp_q;
	logic [3:0]  bit_q;
	logic [8:0]  shf_q;
	logic        rcf_q, ferr_q, oerr_q, d9_q;
	logic [3:0]  brk_q;
	logic [3:0]  brk_smp_q;
	logic        brk_go;
	logic        txo_q;

	logic port_enable_bit, continuous_receive_enable, rx9, address_detect_enable, sync, high_speed_baud_select, b16, rcie, rcip;
	assign port_enable_bit  = rxsc_q[`ESR_RXSC_PORT_ENABLE_BIT];
	assign continuous_receive_enable  = rxsc_q[`ESR_RXSC_CONTINUOUS_RECEIVE_ENABLE];
	assign rx9   = rxsc_q[`ESR_RXSC_RX9];
	assign address_detect_enable = rxsc_q[`ESR_RXSC_ADDRESS_DETECT_ENABLE];
	assign sync  = txsc_q[`ESR_TXSC_SYNC];
	assign high_speed_baud_select  = txsc_q[`ESR_TXSC_HIGH_SPEED_BAUD_SELECT];
	assign b16   = baudc_q[`ESR_BAUDC_B16];
	assign rcie  = intc_q[`ESR_INTC_RCIE];
	assign rcip  = intc_q[`ESR_INTC_RCIP];

	logic async_on;
	assign async_on = port_enable_bit && !sync;

	function automatic logic hit(input logic [2:0] a, input logic [2:0] o);
		hit = (a == o);
	endfunction : hit

	// register writes
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			txsc_q  <= `ESR_ZERO8;
			rxsc_q  <= `ESR_ZERO8;
			baudc_q <= `ESR_ZERO8;
			divl_q  <= `ESR_ZERO8;
			divh_q  <= `ESR_ZERO8;
			intc_q  <= `ESR_ZERO8;
			od_q    <= 1'b0;
		end else if (clk_en && reg_wr) begin
			if (hit(reg_addr, `ESR_OFF_TXSC))
				txsc_q <= reg_wdata;
			if (hit(reg_addr, `ESR_OFF_RXSC))
				rxsc_q <= reg_wdata;
			if (hit(reg_addr, `ESR_OFF_BAUDC))
				baudc_q <= reg_wdata;
			if (hit(reg_addr, `ESR_OFF_DIVL))
				divl_q <= reg_wdata;
			if (hit(reg_addr, `ESR_OFF_DIVH))
				divh_q <= reg_wdata;
			if (hit(reg_addr, `ESR_OFF_INTC))
				intc_q <= reg_wdata;
			if (hit(reg_addr, `ESR_OFF_ODC))
				od_q <= reg_wdata[0];
		end
	end

	// baud generator: tick is the x16 sample rate
	logic [15:0] div_val;
	logic [1:0]  pre_last;
	always_comb begin
		div_val  = b16 ? {divh_q, divl_q} : {8'h00, divl_q};
		pre_last = (b16 || high_speed_baud_select) ? 2'h0 : 2'h3; // low speed without b16 = /4 more
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			brg_cnt_q <= 16'h0000;
			pre_q     <= 2'h0;
			tick_q    <= 1'b0;
		end else if (clk_en) begin
			tick_q <= 1'b0;
			if (!port_enable_bit) begin
				brg_cnt_q <= 16'h0000;
				pre_q     <= 2'h0;
			end else if (brg_cnt_q >= div_val) begin
				brg_cnt_q <= 16'h0000;
				if (pre_q >= pre_last) begin
					pre_q  <= 2'h0;
					tick_q <= 1'b1;
				end else
					pre_q <= pre_q + 2'h1;
			end else
				brg_cnt_q <= brg_cnt_q + 16'h0001;
		end
	end

	// receive state machine, sampled sixteen times per bit
	logic [3:0] last_bit;
	logic       rx_lvl;
	logic       accept;
	assign last_bit = rx9 ? 4'h8 : 4'h7;
	assign rx_lvl   = port_enable_bit ? rx_in : 1'b1;
	assign accept   = !(address_detect_enable && rx9) || shf_q[8];

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_q  <= ESR_IDLE;
			smp_q <= 4'h0;
			bit_q <= 4'h0;
			shf_q <= 9'h000;
		end else if (clk_en) begin
			if (!(async_on && continuous_receive_enable)) begin
				st_q <= ESR_IDLE;
			end else if (tick_q) begin
				smp_q <= smp_q + 4'h1;
				case (st_q)
				ESR_IDLE: begin
					smp_q <= 4'h0;
					if (!rx_lvl)
						st_q <= ESR_START;
				end
				ESR_START: begin
					if (smp_q == `ESR_OSR_MID && rx_lvl)
						st_q <= ESR_IDLE;
					if (smp_q == `ESR_OSR_LAST) begin
						st_q  <= ESR_DATA;
						bit_q <= 4'h0;
					end
				end
				ESR_DATA: begin
					if (smp_q == `ESR_OSR_MID) begin
						shf_q <= {rx_lvl, shf_q[8:1]};
					end
					if (smp_q == `ESR_OSR_LAST) begin
						if (bit_q == last_bit)
							st_q <= ESR_STOP;
						bit_q <= bit_q + 4'h1;
					end
				end
				ESR_STOP: begin
					if (smp_q == `ESR_OSR_MID)
						st_q <= ESR_IDLE;
				end
				default: st_q <= ESR_IDLE;
				endcase
			end
		end
	end

	// character completion, flags and data register
	logic done;
	logic rd_data;
	logic [8:0] chr;
	assign done = clk_en && tick_q && st_q == ESR_STOP &&
		smp_q == `ESR_OSR_MID && async_on && continuous_receive_enable;
	assign rd_data = clk_en && reg_rd && hit(reg_addr, `ESR_OFF_RXDATA);
	assign chr = rx9 ? shf_q : {1'b0, shf_q[8:1]};

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rxdata_q <= `ESR_ZERO8;
			d9_q     <= 1'b0;
			rcf_q    <= 1'b0;
			ferr_q   <= 1'b0;
			oerr_q   <= 1'b0;
		end else if (clk_en) begin
			if (rd_data)
				rcf_q <= 1'b0;
			if (!continuous_receive_enable) begin
				ferr_q <= 1'b0;
				oerr_q <= 1'b0;
			end
			if (done && accept) begin
				if (rcf_q && !rd_data)
					oerr_q <= 1'b1;
				else begin
					rxdata_q <= chr[7:0];
					d9_q     <= chr[8];
					ferr_q   <= !rx_lvl;
					rcf_q    <= 1'b1; // set wins over read
				end
			end
		end
	end

	// interrupt outputs
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			irq_high <= 1'b0;
			irq_low  <= 1'b0;
		end else if (clk_en) begin
			irq_high <= rcf_q && rcie && rcip;
			irq_low  <= rcf_q && rcie && !rcip;
		end
	end

	// transmit pin: idle high, twelve-bit break on request
	// own bit timer, so a break ends even with the receiver stopped
	assign brk_go = async_on && txsc_q[`ESR_TXSC_BRK] && brk_q == 4'h0 &&
		tick_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			brk_q     <= 4'h0;
			brk_smp_q <= 4'h0;
			txo_q     <= 1'b1;
		end else if (clk_en) begin
			if (brk_go) begin
				brk_q     <= `ESR_BRK_BITS;
				brk_smp_q <= 4'h0;
			end else if (brk_q != 4'h0 && tick_q) begin
				brk_smp_q <= brk_smp_q + 4'h1;
				if (brk_smp_q == `ESR_OSR_LAST)
					brk_q <= brk_q - 4'h1;
			end
			txo_q <= !(brk_q != 4'h0 || brk_go);
		end
	end

	// pin direction and drive style
	logic txck_drv;
	assign txck_drv = port_enable_bit && (!sync || txsc_q[`ESR_TXSC_CSRC]);
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			txck_out <= 1'b1;
			txck_oe  <= 1'b0;
			rx_out   <= 1'b1;
			rx_oe    <= 1'b0;
		end else if (clk_en) begin
			txck_out <= txo_q ^ (sync && baudc_q[`ESR_BAUDC_POL]);
			if (od_q)
				txck_oe <= txck_drv && !txo_q;
			else
				txck_oe <= txck_drv;
			rx_out <= 1'b1;
			rx_oe  <= 1'b0; // receive pin is input in async
		end
	end

	// register reads, one cycle later
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			reg_rdata <= `ESR_ZERO8;
		else if (clk_en) begin
			reg_rdata <= `ESR_ZERO8;
			if (reg_rd) begin
				case (reg_addr)
				`ESR_OFF_TXSC:   reg_rdata <= txsc_q;
				`ESR_OFF_RXSC:   reg_rdata <= {rxsc_q[7:3], ferr_q,
					oerr_q, d9_q};
				`ESR_OFF_BAUDC:  reg_rdata <= baudc_q;
				`ESR_OFF_DIVL:   reg_rdata <= divl_q;
				`ESR_OFF_DIVH:   reg_rdata <= divh_q;
				`ESR_OFF_RXDATA: reg_rdata <= rxdata_q;
				`ESR_OFF_ODC:    reg_rdata <= {7'h00, od_q};
				`ESR_OFF_INTC:   reg_rdata <= {intc_q[7:1], rcf_q};
				default:         reg_rdata <= `ESR_ZERO8;
				endcase
			end
		end
	end

	// checks
	a_err_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && !continuous_receive_enable |=> !ferr_q && !oerr_q)
		else $error("receive error survived receive disable");
	a_irq_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && rcf_q && rcie |=> irq_high == rcip && irq_low == !rcip)
		else $error("receive interrupt level wrong");
	a_addr_filter: assert property (@(posedge clk_sys) disable iff (sys_rst)
		done && address_detect_enable && rx9 && !shf_q[8] && !rcf_q |=> !rcf_q)
		else $error("non-address character accepted");
	a_all_accept: assert property (@(posedge clk_sys) disable iff (sys_rst)
		done && !address_detect_enable && !rcf_q |=> rcf_q)
		else $error("character not reported");
	a_pin_release: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && !port_enable_bit |=> !txck_oe && !rx_oe)
		else $error("pin driven while port disabled");
	a_od_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && od_q && txo_q |=> !txck_oe)
		else $error("open drain drove high");
	a_recv_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && !continuous_receive_enable |=> st_q == ESR_IDLE)
		else $error("receiver ran with reception disabled");
	a_data_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
		rd_data |=> reg_rdata == $past(rxdata_q))
		else $error("receive data read wrong");
endmodule : esr_top

// >>> test/esr_node.sv
// remote serial node that sends frames into the receive pin
`timescale 1ns/1ps
module esr_node #(
	parameter int BIT_CLKS = 16 // clocks per bit time on the line
) (
	input  wire logic clk_sys, // system clock
	output logic      line_tx  // serial line, idle high
);
	initial line_tx = 1'b1;

	// start low, lsb first, stop level set by the caller, low to provoke framing errors
	task automatic send(input logic [8:0] d, input int nb, input logic stp);
		for (int i = 0; i < nb + 2; i++) begin
			@(posedge clk_sys);
			line_tx <= (i == 0) ? 1'b0 : (i > nb) ? stp : d[i - 1];
			repeat (BIT_CLKS - 1) @(posedge clk_sys);
		end
		@(posedge clk_sys);
		line_tx <= 1'b1;
	endtask : send
endmodule : esr_node

// >>> test/esr_top_tb.sv
// self-checking bench of the serial receiver
`timescale 1ns/1ps
`include "esr_map.svh"
module esr_top_tb;
	logic       clk_sys   = 1'b0;
	logic       sys_rst   = 1'b1;
	logic [2:0] reg_addr  = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr    = 1'b0;
	logic       reg_rd    = 1'b0;
	logic       clk_en    = 1'b1;
	logic [7:0] reg_rdata;
	logic       rx_line;
	logic       txck_out;
	logic       txck_oe;
	logic       irq_high;
	logic       irq_low;
	logic [7:0] rd_v;
	int         err_total = 0;
	int         n_checks  = 0;

	always #5 clk_sys = ~clk_sys;

	esr_top esr_top_i (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_in(rx_line),
		.rx_out(), .rx_oe(), .txck_in(1'b1), .txck_out(txck_out),
		.txck_oe(txck_oe), .irq_high(irq_high), .irq_low(irq_low)
	);

	esr_node esr_node_i (
		.clk_sys(clk_sys),
		.line_tx(rx_line)
	);

	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1 rd_v = reg_rdata;
	endtask : rd

	task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
		rd(a);
		chk(rd_v, exp);
	endtask : rchk

	task automatic pins(input logic [7:0] exp);
		#1;
		chk({4'h0, txck_oe, txck_out, irq_high, irq_low}, exp);
	endtask : pins

	// whole run needs under two thousand cycles
	initial begin
		#100_000;
		err_total++;
		summarize();
	end

	initial begin
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rchk(`ESR_OFF_RXSC, 8'h00);
		rchk(`ESR_OFF_INTC, 8'h00);
		pins(8'h04);
		@(posedge clk_sys);
		clk_en <= 1'b0;
		wr(`ESR_OFF_DIVL, 8'h55);
		clk_en <= 1'b1;
		rchk(`ESR_OFF_DIVL, 8'h00);
		wr(`ESR_OFF_DIVL, 8'h00);
		wr(`ESR_OFF_TXSC, 8'h24);
		wr(`ESR_OFF_INTC, 8'h06);
		wr(`ESR_OFF_RXSC, 8'h90);
		repeat (2) @(posedge clk_sys);
		pins(8'h0c);
		esr_node_i.send(9'h0a5, 8, 1'b1);
		repeat (2) @(posedge clk_sys);
		pins(8'h0e);
		rchk(`ESR_OFF_INTC, 8'h07);
		esr_node_i.send(9'h05a, 8, 1'b1);
		rchk(`ESR_OFF_RXSC, 8'h92);
		rchk(`ESR_OFF_RXDATA, 8'ha5);
		rchk(`ESR_OFF_INTC, 8'h06);
		wr(`ESR_OFF_RXSC, 8'h80);
		rchk(`ESR_OFF_RXSC, 8'h80);
		esr_node_i.send(9'h033, 8, 1'b1);
		rchk(`ESR_OFF_INTC, 8'h06);
		wr(`ESR_OFF_RXSC, 8'hd0);
		esr_node_i.send(9'h13c, 9, 1'b1);
		rchk(`ESR_OFF_RXSC, 8'hd1);
		rchk(`ESR_OFF_RXDATA, 8'h3c);
		wr(`ESR_OFF_RXSC, 8'hd8);
		esr_node_i.send(9'h055, 9, 1'b1);
		rchk(`ESR_OFF_INTC, 8'h06);
		esr_node_i.send(9'h1aa, 9, 1'b1);
		rchk(`ESR_OFF_RXSC, 8'hd9);
		rchk(`ESR_OFF_RXDATA, 8'haa);
		wr(`ESR_OFF_RXSC, 8'hd0);
		esr_node_i.send(9'h077, 9, 1'b1);
		rchk(`ESR_OFF_RXSC, 8'hd0);
		rchk(`ESR_OFF_RXDATA, 8'h77);
		wr(`ESR_OFF_INTC, 8'h02);
		wr(`ESR_OFF_RXSC, 8'h90);
		esr_node_i.send(9'h044, 8, 1'b1);
		repeat (2) @(posedge clk_sys);
		pins(8'h0d);
		rchk(`ESR_OFF_RXDATA, 8'h44);
		esr_node_i.send(9'h011, 8, 1'b0);
		rd(`ESR_OFF_RXSC);
		chk(rd_v & 8'h04, 8'h04);
		wr(`ESR_OFF_RXSC, 8'h80);
		rd(`ESR_OFF_RXSC);
		chk(rd_v & 8'h06, 8'h00);
		wr(`ESR_OFF_INTC, 8'h00);
		wr(`ESR_OFF_ODC, 8'h01);
		repeat (2) @(posedge clk_sys);
		pins(8'h04);
		wr(`ESR_OFF_TXSC, 8'h2c);
		repeat (3) @(posedge clk_sys);
		pins(8'h08);
		wr(`ESR_OFF_TXSC, 8'h24);
		repeat (200) @(posedge clk_sys);
		pins(8'h04);
		wr(`ESR_OFF_RXSC, 8'h00);
		repeat (2) @(posedge clk_sys);
		#1;
		chk({7'h0, txck_oe}, 8'h00);
		summarize();
	end
endmodule : esr_top_tb
